// [hdl/sport_pkg.sv]
package sport_pkg;
	// Bus geometry.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte offsets.
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] PIN_OFS = 8'h04;
	localparam logic [7:0] RATE_OFS = 8'h08;
	localparam logic [7:0] RXFMT_OFS = 8'h0C;
	localparam logic [7:0] TXFMT_OFS = 8'h10;
	localparam logic [7:0] TXHOLD_OFS = 8'h14;
	localparam logic [7:0] RXDATA_OFS = 8'h18;
	localparam logic [7:0] STAT_OFS = 8'h1C;

	// Writable bits of the control, pin, rate and format registers and the common value after reset.
	localparam logic [31:0] CTRL_MASK = 32'h000000FF;
	localparam logic [31:0] PIN_MASK = 32'h0000000F;
	localparam logic [31:0] RATE_MASK = 32'h10FF0FFF;
	localparam logic [31:0] FMT_MASK = 32'h877F077F;
	localparam logic [31:0] REG_RESET = 32'h00000000;

	// Port control fields.
	localparam int CTRL_RX_EN = 0;
	localparam int CTRL_TX_EN = 1;
	localparam int CTRL_LOOP = 2;
	localparam int CTRL_GEN_RUN = 3;
	localparam int CTRL_RX_IRQ_LSB = 4;
	localparam int CTRL_TX_IRQ_LSB = 6;

	// Pin control fields.
	localparam int PIN_RX_POL = 0;
	localparam int PIN_TX_POL = 1;
	localparam int PIN_RX_DIR = 2;
	localparam int PIN_TX_DIR = 3;

	// Rate generator fields.
	localparam int RATE_PER_LSB = 0;
	localparam int RATE_WID_LSB = 16;
	localparam int RATE_GEN_SEL = 28;

	// Frame format fields, same layout for receive and transmit.
	localparam int FMT_C1_LSB = 0;
	localparam int FMT_W1_LSB = 8;
	localparam int FMT_C2_LSB = 16;
	localparam int FMT_W2_LSB = 24;
	localparam int FMT_PHASE = 31;

	// Status fields.
	localparam int STAT_HOLD_FULL = 0;
	localparam int STAT_RX_READY = 1;
	localparam int STAT_RX_ACTIVE = 2;
	localparam int STAT_TX_ACTIVE = 3;
	localparam int STAT_GEN_PULSE = 4;

	// Interrupt event modes.
	localparam logic [1:0] IRQ_ELEM = 2'h0;
	localparam logic [1:0] IRQ_FRAME_END = 2'h1;
	localparam logic [1:0] IRQ_SYNC = 2'h2;

	// Positions of the pin inputs in the synchroniser vector.
	localparam int SY_RXCLK = 0;
	localparam int SY_TXCLK = 1;
	localparam int SY_RXFS = 2;
	localparam int SY_TXFS = 3;
	localparam int SY_RXD = 4;
	localparam int SY_N = 5;

	typedef enum logic [2:0] {
		FR_IDLE = 3'b001,
		FR_PH1 = 3'b010,
		FR_PH2 = 3'b100
	} frame_state_type;

	// Element width code to bits; reserved codes fall back to eight bits.
	function automatic logic [5:0] elem_bits(input logic [2:0] code);
		case (code)
			3'h0: elem_bits = 6'h08;
			3'h1: elem_bits = 6'h0C;
			3'h2: elem_bits = 6'h10;
			3'h3: elem_bits = 6'h14;
			3'h4: elem_bits = 6'h18;
			3'h5: elem_bits = 6'h20;
			default: elem_bits = 6'h08;
		endcase
	endfunction

	// Event that a given interrupt mode reports.
	function automatic logic irq_event(input logic [1:0] mode, input logic el,
			input logic fl, input logic fs);
		case (mode)
			IRQ_ELEM: irq_event = el;
			IRQ_FRAME_END: irq_event = fl;
			IRQ_SYNC: irq_event = fs;
			default: irq_event = 1'b0;
		endcase
	endfunction
endpackage

// [hdl/frame_link_if.sv]
`timescale 1ns/1ns
interface frame_link_if;
	logic tick;
	logic sync;
	logic run;
	logic phase_sel;
	logic [6:0] c1;
	logic [6:0] c2;
	logic [2:0] w1;
	logic [2:0] w2;
	logic bit_strobe;
	logic elem_last;
	logic frame_last;
	logic frame_start;
	logic active;
	logic [5:0] bit_idx;

	modport ctrl(output tick, sync, run, phase_sel, c1, c2, w1, w2,
		input bit_strobe, elem_last, frame_last, frame_start, active, bit_idx);
	modport frm(input tick, sync, run, phase_sel, c1, c2, w1, w2,
		output bit_strobe, elem_last, frame_last, frame_start, active, bit_idx);
endinterface

// [hdl/frame_pulse_gen.sv]
`timescale 1ns/1ns
module frame_pulse_gen (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic run,
	input wire logic [11:0] period,
	input wire logic [7:0] width,
	output logic pulse
);
	import sport_pkg::*;

	logic [11:0] per_q;
	logic [7:0] wid_q;
	logic [8:0] hi_ticks_q;

	// Both counters restart whenever the generator is stopped, so a fresh run starts a frame.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pulse <= 1'b0;
			per_q <= 12'h000;
			wid_q <= 8'h00;
		end else if (!run) begin
			pulse <= 1'b0; // R18
			per_q <= 12'h000;
			wid_q <= 8'h00;
		end else if (tick) begin
			if (per_q == 12'h000) begin
				per_q <= period; // R19
				wid_q <= width;
				pulse <= 1'b1;
			end else begin
				per_q <= per_q - 12'h001;
				if (wid_q == 8'h00) begin
					pulse <= 1'b0; // R19
				end else begin
					wid_q <= wid_q - 8'h01;
				end
			end
		end
	end

	// Helper count of bit clocks seen while the pulse is high.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hi_ticks_q <= 9'h000;
		end else if (!pulse) begin
			hi_ticks_q <= 9'h000;
		end else if (tick) begin
			hi_ticks_q <= hi_ticks_q + 9'h001;
		end
	end

	chk_gen_quiet_stop: assert property (@(posedge mclk) disable iff (!rst_n) // R18
		!run |=> !pulse)
		else $error("frame pulse present while generator stopped");

	chk_gen_pulse_width: assert property (@(posedge mclk) disable iff (!rst_n) // R19
		(!pulse && $past(pulse) && $past(run) && $stable(width))
		|-> $past(hi_ticks_q) == {1'b0, width})
		else $error("frame pulse high time differs from width plus one");
endmodule

// [hdl/frame_counter.sv]
`timescale 1ns/1ns
module frame_counter (
	input wire logic mclk,
	input wire logic rst_n,
	frame_link_if.frm f
);
	import sport_pkg::*;

	frame_state_type state_q;
	logic [5:0] bit_left_q;
	logic [6:0] elem_left_q;
	logic dual_next;
	logic ending;
	logic [5:0] cur_bits;

	// The second phase fields are only looked at once the second phase is entered.
	assign dual_next = (state_q == FR_PH1) && f.phase_sel; // R10 R13
	assign ending = (state_q == FR_IDLE) ||
		((bit_left_q == 6'h00) && (elem_left_q == 7'h00) && !dual_next);
	assign cur_bits = elem_bits((state_q == FR_PH2) ? f.w2 : f.w1); // R14
	assign f.active = (state_q != FR_IDLE);
	assign f.bit_idx = bit_left_q;

	// One bit is handled on every bit clock inside a frame, so elements and phases abut.
	// A sync that comes in mid-frame is ignored; one on the closing clock starts the next frame.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= FR_IDLE;
			bit_left_q <= 6'h00;
			elem_left_q <= 7'h00;
			f.bit_strobe <= 1'b0;
			f.elem_last <= 1'b0;
			f.frame_last <= 1'b0;
			f.frame_start <= 1'b0;
		end else begin
			f.bit_strobe <= 1'b0;
			f.elem_last <= 1'b0;
			f.frame_last <= 1'b0;
			f.frame_start <= 1'b0;
			if (!f.run) begin
				state_q <= FR_IDLE;
				bit_left_q <= 6'h00;
				elem_left_q <= 7'h00;
			end else if (f.tick) begin
				if (ending && f.sync) begin
					state_q <= FR_PH1;
					elem_left_q <= f.c1; // R12
					bit_left_q <= elem_bits(f.w1) - 6'h01;
					f.bit_strobe <= 1'b1;
					f.frame_start <= 1'b1;
				end else if (ending) begin
					state_q <= FR_IDLE;
				end else if (bit_left_q != 6'h00) begin
					bit_left_q <= bit_left_q - 6'h01;
					f.bit_strobe <= 1'b1;
					f.elem_last <= (bit_left_q == 6'h01);
					f.frame_last <= (bit_left_q == 6'h01) && (elem_left_q == 7'h00) && !dual_next;
				end else if (elem_left_q != 7'h00) begin
					elem_left_q <= elem_left_q - 7'h01; // R11 R12
					bit_left_q <= cur_bits - 6'h01;
					f.bit_strobe <= 1'b1;
				end else begin
					state_q <= FR_PH2; // R11 R15
					elem_left_q <= f.c2;
					bit_left_q <= elem_bits(f.w2) - 6'h01;
					f.bit_strobe <= 1'b1;
				end
			end
		end
	end

	chk_phase_two_dual: assert property (@(posedge mclk) disable iff (!rst_n) // R10
		(state_q == FR_PH2) |-> $past(f.phase_sel) || $past(state_q == FR_PH2))
		else $error("second phase entered in a single-phase frame");

	chk_no_idle_gap: assert property (@(posedge mclk) disable iff (!rst_n) // R11
		(f.run && f.tick && !ending) |=> f.bit_strobe)
		else $error("idle bit clock inside a frame");

	chk_first_elem_width: assert property (@(posedge mclk) disable iff (!rst_n) // R14
		(f.run && f.tick && ending && f.sync) |=> f.bit_idx == elem_bits($past(f.w1)) - 6'h01)
		else $error("first element width not taken from its width code");
endmodule

// [hdl/frame_sync_port.sv]
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
// How it works
// [R1] Loopback takes receive sync from transmit sync and receive data from transmit data.
// [R2] No loopback, receive sync input: pin level, polarity applied, is receive sync.
// [R3] No loopback, receive sync output: generator pulse is receive sync, driven on pin.
// [R4] Loopback with receive sync input: transmit sync used, receive sync pin floats.
// [R5] Loopback with receive sync output: transmit sync used and driven on receive pin.
// [R6] Transmit sync input: pin level, polarity applied, is transmit sync, any generator select.
// [R7] Transmit sync output from generator: generator pulse is sync, driven on pin.
// [R8] Transmit sync output, no generator: each holding-to-shift copy makes one-bit-clock sync; the code makes one only for a copy outside a frame.
// [R9] Interrupt mode two reports accepted frame syncs when that direction is enabled.
// [R10] Phase select zero gives single-phase frames, one gives dual-phase frames.
// [R11] Bits of a frame follow back to back across elements and phases.
// [R12] Element count fields hold elements minus one, seven bits each.
// [R13] Single-phase frames never use the second phase count and width.
// [R14] Width codes give 8, 12, 16, 20, 24, 32 bits; reserved codes act as 8.
// [R15] At most 128 elements single-phase and 256 dual-phase.
// [R16] Software keeps generated frames at or below 4096 bits in total.
// [R17] Receive and transmit each keep separate phase counts and widths.
// [R18] Generator pulses only while running with generator select set; low after reset.
// [R19] Pulse high for width plus one bit clocks, period plus one apart.
// [R20] Polarity zero means active-high sync; one inverts the pin level.
module frame_sync_port (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [sport_pkg::ADDR_W-1:0] paddr,
	input wire logic [sport_pkg::DATA_W-1:0] pwdata,
	output logic [sport_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_bit_clk,
	input wire logic tx_bit_clk,
	input wire logic rx_serial_in,
	output logic tx_serial_out,
	input wire logic rx_sync_in,
	output logic rx_sync_out,
	output logic rx_sync_oe_n,
	input wire logic tx_sync_in,
	output logic tx_sync_out,
	output logic tx_sync_oe_n,
	output logic rx_irq,
	output logic tx_irq
);
	import sport_pkg::*;

	logic [31:0] ctrl_q;
	logic [31:0] pin_q;
	logic [31:0] rate_q;
	logic [31:0] rxfmt_q;
	logic [31:0] txfmt_q;
	logic [31:0] tx_hold_q;
	logic [31:0] tx_shift_q;
	logic [31:0] rx_shift_q;
	logic [31:0] rx_data_q;
	logic hold_full_q;
	logic tx_empty_q;
	logic rx_ready_q;
	logic rx_bit_q;
	logic tx_end_q;
	logic copy_pend_q;
	logic copy_fs_q;
	logic loop_fs_q;
	logic rx_clk_prev_q;
	logic [SY_N-1:0] pin_s1_q;
	logic [SY_N-1:0] pin_s2_q;
	logic [SY_N-1:0] pin_s3_q;
	logic [31:0] rd_mux;
	logic rd_hit;
	logic acc;
	logic wr_en;
	logic loopback_sel, frame_gen_run, rx_en, tx_en;
	logic rx_sync_dir, tx_sync_dir, rx_sync_pol, tx_sync_pol, tx_sync_gen_sel;
	logic [1:0] rx_irq_mode, tx_irq_mode;
	logic gen_frame_pulse;
	logic rx_sync_internal, tx_sync_internal;
	logic tx_tick, rx_tick, rx_clk_now;
	logic copy, copy_mode;

	frame_link_if rxf();
	frame_link_if txf();

	// Control fields pulled out of the configuration words.
	assign rx_en = ctrl_q[CTRL_RX_EN];
	assign tx_en = ctrl_q[CTRL_TX_EN];
	assign loopback_sel = ctrl_q[CTRL_LOOP];
	assign frame_gen_run = ctrl_q[CTRL_GEN_RUN];
	assign rx_irq_mode = ctrl_q[CTRL_RX_IRQ_LSB +: 2];
	assign tx_irq_mode = ctrl_q[CTRL_TX_IRQ_LSB +: 2];
	assign rx_sync_pol = pin_q[PIN_RX_POL];
	assign tx_sync_pol = pin_q[PIN_TX_POL];
	assign rx_sync_dir = pin_q[PIN_RX_DIR];
	assign tx_sync_dir = pin_q[PIN_TX_DIR];
	assign tx_sync_gen_sel = rate_q[RATE_GEN_SEL];

	// APB: zero wait states, the access phase completes in its first cycle.
	assign acc = psel && penable && pready;
	assign wr_en = acc && pwrite;

	// Read multiplexer; an unmapped address reads zero and flags an error.
	always_comb begin
		rd_mux = REG_RESET;
		rd_hit = 1'b1;
		case (paddr)
			CTRL_OFS: rd_mux = ctrl_q;
			PIN_OFS: rd_mux = pin_q;
			RATE_OFS: rd_mux = rate_q;
			RXFMT_OFS: rd_mux = rxfmt_q;
			TXFMT_OFS: rd_mux = txfmt_q;
			TXHOLD_OFS: rd_mux = tx_hold_q;
			RXDATA_OFS: rd_mux = rx_data_q;
			STAT_OFS: begin
				rd_mux[STAT_HOLD_FULL] = hold_full_q;
				rd_mux[STAT_RX_READY] = rx_ready_q;
				rd_mux[STAT_RX_ACTIVE] = rxf.active;
				rd_mux[STAT_TX_ACTIVE] = txf.active;
				rd_mux[STAT_GEN_PULSE] = gen_frame_pulse;
			end
			default: rd_hit = 1'b0;
		endcase
	end

	// Read data and error are captured in the setup cycle and held through the access.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			prdata <= REG_RESET;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			if (psel && !penable) begin
				prdata <= rd_mux;
				pslverr <= !rd_hit;
			end else if (acc) begin
				pslverr <= 1'b0;
			end
		end
	end

	// Configuration words; each direction keeps its own frame format.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= REG_RESET;
			pin_q <= REG_RESET;
			rate_q <= REG_RESET;
			rxfmt_q <= REG_RESET;
			txfmt_q <= REG_RESET;
		end else if (wr_en) begin
			case (paddr)
				CTRL_OFS: ctrl_q <= pwdata & CTRL_MASK;
				PIN_OFS: pin_q <= pwdata & PIN_MASK;
				RATE_OFS: rate_q <= pwdata & RATE_MASK;
				RXFMT_OFS: rxfmt_q <= pwdata & FMT_MASK; // R17
				TXFMT_OFS: txfmt_q <= pwdata & FMT_MASK; // R17
				default: ;
			endcase
		end
	end

	// Pin inputs pass two flops; the third stage only serves edge finding on the transmit clock.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			pin_s3_q <= '0;
			rx_clk_prev_q <= 1'b0;
		end else begin
			pin_s1_q <= {rx_serial_in, tx_sync_in, rx_sync_in, tx_bit_clk, rx_bit_clk};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			rx_clk_prev_q <= rx_clk_now;
		end
	end

	// Transmit works on rising bit clock edges, receive samples on falling ones.
	// In loopback the receiver follows the transmit clock, so both sides share one bit time.
	assign tx_tick = pin_s2_q[SY_TXCLK] && !pin_s3_q[SY_TXCLK];
	assign rx_clk_now = loopback_sel ? pin_s2_q[SY_TXCLK] : pin_s2_q[SY_RXCLK];
	assign rx_tick = rx_clk_prev_q && !rx_clk_now;

	// The generator counts transmit bit clocks.
	frame_pulse_gen u_gen (
		.mclk(mclk),
		.rst_n(rst_n),
		.tick(tx_tick),
		.run(frame_gen_run && tx_sync_gen_sel), // R18
		.period(rate_q[RATE_PER_LSB +: 12]),
		.width(rate_q[RATE_WID_LSB +: 8]),
		.pulse(gen_frame_pulse)
	);

	// Internal frame syncs, all active high.
	always_comb begin
		if (!tx_sync_dir) begin
			tx_sync_internal = pin_s2_q[SY_TXFS] ^ tx_sync_pol; // R6 R20
		end else if (tx_sync_gen_sel) begin
			tx_sync_internal = gen_frame_pulse; // R7
		end else begin
			tx_sync_internal = copy_fs_q; // R8
		end
		if (loopback_sel) begin
			rx_sync_internal = loop_fs_q; // R1 R4 R5
		end else if (rx_sync_dir) begin
			rx_sync_internal = gen_frame_pulse; // R3
		end else begin
			rx_sync_internal = pin_s2_q[SY_RXFS] ^ rx_sync_pol; // R2 R20
		end
	end

	// Sync pins; the enable is low only while the pin drives.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rx_sync_out <= 1'b0;
			rx_sync_oe_n <= 1'b1;
			tx_sync_out <= 1'b0;
			tx_sync_oe_n <= 1'b1;
		end else begin
			rx_sync_oe_n <= !rx_sync_dir; // R2 R4
			rx_sync_out <= (loopback_sel ? tx_sync_internal : gen_frame_pulse) ^ rx_sync_pol; // R3 R5
			tx_sync_oe_n <= !tx_sync_dir; // R6
			tx_sync_out <= tx_sync_internal ^ tx_sync_pol; // R7 R8 R20
		end
	end

	// Framer hookup; count fields hold elements minus one, so 7 bits reach 128 per phase.
	assign rxf.tick = rx_tick;
	assign rxf.sync = rx_sync_internal;
	assign rxf.run = rx_en;
	assign rxf.phase_sel = rxfmt_q[FMT_PHASE]; // R10
	assign rxf.c1 = rxfmt_q[FMT_C1_LSB +: 7]; // R12 R15
	assign rxf.c2 = rxfmt_q[FMT_C2_LSB +: 7];
	assign rxf.w1 = rxfmt_q[FMT_W1_LSB +: 3];
	assign rxf.w2 = rxfmt_q[FMT_W2_LSB +: 3];
	assign txf.tick = tx_tick;
	assign txf.sync = tx_sync_internal;
	assign txf.run = tx_en;
	assign txf.phase_sel = txfmt_q[FMT_PHASE]; // R10
	assign txf.c1 = txfmt_q[FMT_C1_LSB +: 7]; // R12 R15
	assign txf.c2 = txfmt_q[FMT_C2_LSB +: 7];
	assign txf.w1 = txfmt_q[FMT_W1_LSB +: 3];
	assign txf.w2 = txfmt_q[FMT_W2_LSB +: 3];

	frame_counter u_rx_frame (
		.mclk(mclk),
		.rst_n(rst_n),
		.f(rxf)
	);

	frame_counter u_tx_frame (
		.mclk(mclk),
		.rst_n(rst_n),
		.f(txf)
	);

	// Holding to shift copy; an underrun just sends the stale word again.
	assign copy = tx_empty_q && hold_full_q && tx_en;
	assign copy_mode = tx_sync_dir && !tx_sync_gen_sel;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tx_hold_q <= REG_RESET;
			hold_full_q <= 1'b0;
			tx_shift_q <= REG_RESET;
			tx_empty_q <= 1'b1;
		end else begin
			if (wr_en && (paddr == TXHOLD_OFS)) begin
				tx_hold_q <= pwdata;
				hold_full_q <= 1'b1;
			end else if (copy) begin
				hold_full_q <= 1'b0;
			end
			if (copy) begin
				tx_shift_q <= tx_hold_q;
				tx_empty_q <= 1'b0;
			end else if (txf.elem_last) begin
				tx_empty_q <= 1'b1;
			end
		end
	end

	// A copy outside a frame asks for a sync, issued as exactly one bit clock period.
	// Loopback hands the receiver the sync as the transmit edge that starts the frame saw it.
	// Taken raw, it would meet a falling edge before the first transmit bit is out.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tx_end_q <= 1'b0;
			copy_pend_q <= 1'b0;
			copy_fs_q <= 1'b0;
			loop_fs_q <= 1'b0;
		end else begin
			if (txf.frame_last) begin
				tx_end_q <= 1'b1;
			end else if (txf.frame_start) begin
				tx_end_q <= 1'b0;
			end
			if (copy && copy_mode && (!txf.active || tx_end_q)) begin
				copy_pend_q <= 1'b1; // R8
			end else if (tx_tick) begin
				copy_pend_q <= 1'b0;
			end
			if (tx_tick) begin
				copy_fs_q <= copy_pend_q && copy_mode; // R8
				loop_fs_q <= tx_sync_internal; // R1
			end
		end
	end

	// Serial data; elements go out MSB first from their right-justified word.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tx_serial_out <= 1'b0;
			rx_bit_q <= 1'b0;
			rx_shift_q <= REG_RESET;
			rx_data_q <= REG_RESET;
			rx_ready_q <= 1'b0;
		end else begin
			if (txf.bit_strobe) begin
				tx_serial_out <= tx_shift_q[txf.bit_idx[4:0]];
			end
			if (rx_tick) begin
				rx_bit_q <= loopback_sel ? tx_serial_out : pin_s2_q[SY_RXD]; // R1
			end
			if (rxf.elem_last) begin
				rx_data_q <= {rx_shift_q[30:0], rx_bit_q};
				rx_shift_q <= REG_RESET;
			end else if (rxf.bit_strobe) begin
				rx_shift_q <= {rx_shift_q[30:0], rx_bit_q};
			end
			if (rxf.elem_last) begin
				rx_ready_q <= 1'b1;
			end else if (acc && !pwrite && (paddr == RXDATA_OFS)) begin
				rx_ready_q <= 1'b0;
			end
		end
	end

	// Event lines, one-cycle pulses, silent while that direction is held off.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rx_irq <= 1'b0;
			tx_irq <= 1'b0;
		end else begin
			rx_irq <= rx_en && irq_event(rx_irq_mode, rxf.elem_last, rxf.frame_last,
				rxf.frame_start); // R9
			tx_irq <= tx_en && irq_event(tx_irq_mode, txf.elem_last, txf.frame_last,
				txf.frame_start); // R9
		end
	end

	chk_loop_data_path: assert property (@(posedge mclk) disable iff (!rst_n) // R1
		(loopback_sel && rx_tick) |=> rx_bit_q == $past(tx_serial_out))
		else $error("loopback receive bit not taken from transmit data");

	chk_rx_pin_input: assert property (@(posedge mclk) disable iff (!rst_n) // R2
		(!loopback_sel && !rx_sync_dir && rxf.run && rx_tick && !rxf.active
		&& (pin_s2_q[SY_RXFS] != rx_sync_pol)) |=> rxf.frame_start)
		else $error("receive pin sync not accepted");

	chk_rx_pin_gen: assert property (@(posedge mclk) disable iff (!rst_n) // R3
		(!loopback_sel && rx_sync_dir) |=> !rx_sync_oe_n
		&& rx_sync_out == ($past(gen_frame_pulse) ^ $past(rx_sync_pol)))
		else $error("receive sync pin does not carry generator pulse");

	chk_rx_pin_float: assert property (@(posedge mclk) disable iff (!rst_n) // R4
		(loopback_sel && !rx_sync_dir) |=> rx_sync_oe_n)
		else $error("receive sync pin driven in loopback input mode");

	chk_rx_pin_loop: assert property (@(posedge mclk) disable iff (!rst_n) // R5
		(loopback_sel && rx_sync_dir) |=> !rx_sync_oe_n
		&& rx_sync_out == ($past(tx_sync_internal) ^ $past(rx_sync_pol)))
		else $error("receive sync pin does not follow transmit sync");

	chk_tx_pin_input: assert property (@(posedge mclk) disable iff (!rst_n) // R6
		!tx_sync_dir |=> tx_sync_oe_n)
		else $error("transmit sync pin driven while an input");

	chk_tx_pin_gen: assert property (@(posedge mclk) disable iff (!rst_n) // R7
		(tx_sync_dir && tx_sync_gen_sel) |=> !tx_sync_oe_n
		&& tx_sync_out == ($past(gen_frame_pulse) ^ $past(tx_sync_pol)))
		else $error("transmit sync pin does not carry generator pulse");

	chk_copy_sync_width: assert property (@(posedge mclk) disable iff (!rst_n) // R8
		(copy_fs_q && tx_tick) |=> !copy_fs_q)
		else $error("copy frame sync wider than one bit clock");

	chk_sync_irq_mode: assert property (@(posedge mclk) disable iff (!rst_n) // R9
		(rx_irq_mode == IRQ_SYNC && rx_en && rxf.frame_start) |=> rx_irq)
		else $error("frame sync not reported on receive event line");
endmodule

// [test/codec_model.sv]
`timescale 1ns/1ns
// Far-side codec: makes the bit clock while run is high and takes in transmit frames.
module codec_model (
	input wire logic run,
	input wire logic tx_sync_out,
	input wire logic tx_serial_out,
	output logic bit_clk,
	output logic rx_data,
	output logic [7:0] word
);
	int left = 0;
	initial begin
		bit_clk = 1'b0;
		rx_data = 1'b0;
		word = 8'h00;
	end
	// The clock stands still while run is low, so the port sees no stray edges.
	always begin
		#40;
		bit_clk = run ? ~bit_clk : 1'b0;
	end
	// Unused receive pin toggles every bit, so a stale level is never mistaken for data.
	always @(posedge bit_clk) begin
		rx_data <= ~rx_data;
	end
	// A sync seen high starts eight MSB-first samples on the following falling edges.
	always @(negedge bit_clk) begin
		if (left > 0) begin
			word <= {word[6:0], tx_serial_out};
			left <= left - 1;
		end else if (tx_sync_out === 1'b1) begin
			left <= 8;
		end
	end
endmodule

// [test/frame_sync_port_tb.sv]
`timescale 1ns/1ns
// Drives the port through its register bus and judges the sync pins and the codec's view.
module frame_sync_port_tb;
	import sport_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic run = 1'b0;
	logic fs_rx = 1'b1;
	logic fs_tx = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, q;
	logic [7:0] word;
	logic pready, pslverr, err, tx_serial_out, rx_sync_out, rx_sync_oe_n;
	logic tx_sync_out, tx_sync_oe_n, rx_irq, tx_irq, bit_clk, rx_data;
	int mismatches = 0;
	int n_checks = 0;
	int n_rx_irq = 0;
	int n_tx_irq = 0;
	// Sync pin inputs idle high; only the external sync scenario pulses them low.
	frame_sync_port dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_bit_clk(bit_clk), .tx_bit_clk(bit_clk), .rx_serial_in(rx_data),
		.tx_serial_out(tx_serial_out), .rx_sync_in(fs_rx), .rx_sync_out(rx_sync_out),
		.rx_sync_oe_n(rx_sync_oe_n), .tx_sync_in(fs_tx), .tx_sync_out(tx_sync_out),
		.tx_sync_oe_n(tx_sync_oe_n), .rx_irq(rx_irq), .tx_irq(tx_irq));
	codec_model codec (.run(run), .tx_sync_out(tx_sync_out), .tx_serial_out(tx_serial_out),
		.bit_clk(bit_clk), .rx_data(rx_data), .word(word));
	always #2 mclk = ~mclk;
	// Interrupts are one-cycle pulses, so counting sampled highs counts events.
	always @(posedge mclk) begin
		n_rx_irq += (rx_irq === 1'b1);
		n_tx_irq += (tx_irq === 1'b1);
	end
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", what, e, g);
		end
	endtask
	// One bus transfer; an idle cycle follows so a new setup never lands on the release.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic t_regs;
		apb(1'b0, CTRL_OFS, 32'h0);
		chk("ctrl reset", REG_RESET, q);
		apb(1'b1, RXFMT_OFS, 32'hFFFFFFFF);
		apb(1'b0, RXFMT_OFS, 32'h0);
		chk("rx format", FMT_MASK, q);
		apb(1'b0, TXFMT_OFS, 32'h0);
		chk("tx format apart", REG_RESET, q);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
	endtask
	task automatic t_pins;
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, CTRL_OFS, {29'h0, i[0], 2'h0});
			apb(1'b1, PIN_OFS, {29'h0, i[1], 2'h0});
			// The enables are registered after the write lands, so one more edge passes.
			@(posedge mclk);
			chk("rx pin enable", {31'h0, ~i[1]}, {31'h0, rx_sync_oe_n});
			chk("tx pin enable", 32'h1, {31'h0, tx_sync_oe_n});
		end
	endtask
	// Copy-made sync in loopback: phase two fields hold junk that must not count.
	task automatic t_copy;
		int n;
		apb(1'b1, PIN_OFS, 32'h00000008);
		apb(1'b1, RATE_OFS, 32'h0);
		apb(1'b1, TXFMT_OFS, 32'h057F0000);
		apb(1'b1, RXFMT_OFS, 32'h057F0000);
		apb(1'b1, CTRL_OFS, 32'h000000A7);
		n_rx_irq = 0;
		n_tx_irq = 0;
		run <= 1'b1;
		apb(1'b1, TXHOLD_OFS, 32'hFFFFFFA5);
		n = 0;
		q = 32'h0;
		while (q[STAT_RX_READY] !== 1'b1 && n < 300) begin
			apb(1'b0, STAT_OFS, 32'h0);
			n++;
		end
		chk("codec word", 32'hA5, {24'h0, word});
		apb(1'b0, RXDATA_OFS, 32'h0);
		chk("loopback data", 32'hA5, q);
		chk("rx sync irqs", 32'h1, n_rx_irq);
		chk("tx sync irqs", 32'h1, n_tx_irq);
		run <= 1'b0;
	endtask
	// Generator with width 1 and period 5; a frame of six bits keeps well inside the limit.
	task automatic t_gen;
		int n;
		logic [6:0] seen;
		logic all_hi;
		apb(1'b1, CTRL_OFS, 32'h0000000A);
		apb(1'b1, RATE_OFS, 32'h10010005);
		run <= 1'b1;
		n = 0;
		while (tx_sync_out !== 1'b1 && n < 300) begin
			@(posedge mclk);
			n++;
		end
		for (int i = 0; i < 7; i++) begin
			@(negedge bit_clk);
			seen[i] = tx_sync_out;
		end
		chk("generated sync", 32'h43, {25'h0, seen});
		chk("tx pin driven", 32'h0, {31'h0, tx_sync_oe_n});
		@(posedge mclk);
		apb(1'b1, RATE_OFS, 32'h00010005);
		apb(1'b1, PIN_OFS, 32'h0000000A);
		all_hi = 1'b1;
		repeat (16) begin
			@(negedge bit_clk);
			all_hi = all_hi & (tx_sync_out === 1'b1);
		end
		chk("idle inverted sync", 32'h1, {31'h0, all_hi});
		@(posedge mclk);
		run <= 1'b0;
	endtask
	// External syncs, active low through inverted polarity, one bit clock long.
	task automatic t_ext;
		apb(1'b1, CTRL_OFS, 32'h0);
		apb(1'b1, PIN_OFS, 32'h00000003);
		apb(1'b1, CTRL_OFS, 32'h000000A3);
		n_rx_irq = 0;
		n_tx_irq = 0;
		run <= 1'b1;
		@(negedge bit_clk);
		fs_rx <= 1'b0;
		fs_tx <= 1'b0;
		@(negedge bit_clk);
		fs_rx <= 1'b1;
		fs_tx <= 1'b1;
		repeat (12) @(negedge bit_clk);
		chk("rx pin sync irqs", 32'h1, n_rx_irq);
		chk("tx pin sync irqs", 32'h1, n_tx_irq);
		@(posedge mclk);
		run <= 1'b0;
	endtask
	task automatic test_done;
		if (mismatches == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		t_regs();
		t_pins();
		t_copy();
		t_gen();
		t_ext();
		test_done();
	end
	// The whole run needs under 5 us; twenty times that means a hang.
	initial begin
		#100000;
		mismatches++;
		test_done();
	end
endmodule
